// ### rtl/host_supervision_defs.svh
// Offsets, codes and timing counts of the host supervision timer block
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// - Expiry query answer: byte count 1, then 0x00 clear or 0x01 expired.
// - Unservable request answers function code plus 0x80 and one exception code.
// - Period answer has byte count 2; value 0..0x00FF in 0.1 s units.
// - Host-alive via 0x03 or 0x04 with data 0x0000 is accepted and never answered; other data gets exception 0x03.
// - Function 0x05 item 0x0104: 0xFF00 enables, 0x0000 disables the timer.
// - Function 0x05 item 0x010D with 0xFF00 clears the expiry flag.
// - Successful single write echoes function, item and value as received.
// - Function 0x06 item 0x01E8 loads period 0..0x00FF and echoes item and value.
`ifndef HOST_SUPERVISION_DEFS_SVH
`define HOST_SUPERVISION_DEFS_SVH

// Function codes
`define FN_READ_COILS 8'h01
`define FN_READ_HOLDING 8'h03
`define FN_READ_INPUT 8'h04
`define FN_WRITE_COIL 8'h05
`define FN_WRITE_REG 8'h06
`define FN_EXCEPTION_BIT 8'h80

// Item addresses
`define ITEM_ENABLE_COIL 16'h0104
`define ITEM_EXPIRY_FLAG 16'h010D
`define ITEM_PERIOD 16'h01E8
`define ITEM_HOST_ALIVE 16'h3038

// Data values
`define QTY_ONE 16'h0001
`define COIL_ON 16'hFF00
`define COIL_OFF 16'h0000
`define ALIVE_DATA 16'h0000
`define PERIOD_MAX 16'h00FF

// Exception codes
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03

// Reply lengths in bytes after the function code
`define LEN_EXPIRY 3'h2
`define LEN_PERIOD 3'h3
`define LEN_ECHO 3'h4
`define LEN_EXCEPTION 3'h1

// Reset values
`define RST_PERIOD 8'h00
`define RST_ENABLE 1'b0

// Timing: one countdown step in ns and in core clock cycles
`define STEP_NS 100000000
`define CLK_PERIOD_NS 10
`define STEP_CYCLES (`STEP_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/host_supervision_pkg.sv
// Types shared by the host supervision timer block
package host_supervision_pkg;

  // Kind of reply produced for one request
  typedef enum logic [1:0] {
    RSP_NONE,
    RSP_DATA,
    RSP_EXCEPTION
  } rsp_kind_t;

endpackage : host_supervision_pkg

// ### rtl/step_tick.sv
// Free running divider giving one enable pulse per countdown step
`timescale 1ns/1ps
`include "host_supervision_defs.svh"

module step_tick #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Restart the step phase
  input wire logic restart,
  // One-cycle step pulse
  output logic tick
);

  localparam int unsigned CW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

  logic [CW-1:0] cnt_r;
  wire at_last = (cnt_r == LAST);

  // Restart aligns the first step to a full period after a reload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= (restart || at_last) ? '0 : cnt_r + 1'b1;
      tick <= at_last && !restart;
    end
  end

endmodule : step_tick

// ### rtl/host_supervision_timer.sv
// Host supervision timer: decoded request handling, countdown and replies
`timescale 1ns/1ps
`include "host_supervision_defs.svh"

module host_supervision_timer #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Decoded request from the frame layer, addressed to this module
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  // Reply to the frame layer, payload bytes MSB first after the function code
  output logic rsp_valid,
  output logic [7:0] rsp_func,
  output logic [2:0] rsp_len,
  output logic [31:0] rsp_payload,
  // Visible timer state
  output logic timer_enabled,
  output logic expiry_flag,
  output logic [7:0] period_value
);

  //------------------------------------------------------------
  // Request decode
  //------------------------------------------------------------
  wire fn_rd_coil = (req_func == `FN_READ_COILS);
  wire fn_rd_hold = (req_func == `FN_READ_HOLDING);
  wire fn_rd_inp = (req_func == `FN_READ_INPUT);
  wire fn_wr_coil = (req_func == `FN_WRITE_COIL);
  wire fn_wr_reg = (req_func == `FN_WRITE_REG);
  wire fn_known = fn_rd_coil | fn_rd_hold | fn_rd_inp | fn_wr_coil | fn_wr_reg;

  wire at_enable = (req_addr == `ITEM_ENABLE_COIL);
  wire at_expiry = (req_addr == `ITEM_EXPIRY_FLAG);
  wire at_period = (req_addr == `ITEM_PERIOD);
  wire at_alive = (req_addr == `ITEM_HOST_ALIVE);

  wire val_on = (req_data == `COIL_ON);
  wire val_off = (req_data == `COIL_OFF);
  wire qty_one = (req_data == `QTY_ONE);

  // Host-alive is taken on either register read function, 0x03 or 0x04
  wire is_alive = (fn_rd_hold | fn_rd_inp) & at_alive;
  wire alive_ok = is_alive & (req_data == `ALIVE_DATA);

  // Query forms
  wire rd_expiry = fn_rd_coil & at_expiry;
  wire rd_period = fn_rd_hold & at_period;

  // Write forms; only exact coil values are legal
  wire wr_enable = fn_wr_coil & at_enable;
  wire wr_clear = fn_wr_coil & at_expiry;
  wire enable_ok = wr_enable & (val_on | val_off);
  wire clear_ok = wr_clear & val_on;
  wire wr_period = fn_wr_reg & at_period;
  wire period_ok = wr_period & (req_data <= `PERIOD_MAX);

  // Address recognised for the function used
  wire addr_ok = rd_expiry | rd_period | is_alive | wr_enable | wr_clear | wr_period;
  // Value or quantity acceptable
  wire value_ok = (rd_expiry & qty_one) | (rd_period & qty_one) | alive_ok
                | enable_ok | clear_ok | period_ok;

  // Exception code choice, function first, then address, then value
  wire [7:0] exc_code = !fn_known ? `EXC_ILLEGAL_FUNCTION :
                        !addr_ok ? `EXC_ILLEGAL_ADDRESS : `EXC_ILLEGAL_VALUE;

  wire take = req_valid;
  wire alive_now = take & alive_ok;
  wire enable_now = take & enable_ok;
  wire clear_now = take & clear_ok;
  wire period_now = take & period_ok;

  //------------------------------------------------------------
  // Control state
  //------------------------------------------------------------
  logic enable_r;
  logic enable_nxt;
  logic expiry_r;
  logic expiry_nxt;
  logic [7:0] period_r;
  logic [7:0] period_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic tick;

  // Enable follows the coil value only when it is a legal one
  assign enable_nxt = enable_now ? val_on : enable_r;
  assign period_nxt = period_now ? req_data[7:0] : period_r;

  // Any reload restarts both count and step phase
  wire reload = alive_now | period_now | (enable_now & val_on & !enable_r);

  // Expiry when the last step runs out; a zero period expires on the first step
  wire run = enable_r & tick;
  wire hit_zero = run & (count_r <= 8'h01) & !reload;

  // Countdown holds at zero until the next reload
  assign count_nxt = reload ? period_nxt :
                     (run && count_r != 8'h00) ? count_r - 8'h01 : count_r;

  // Set wins over a clear arriving in the same cycle
  assign expiry_nxt = hit_zero | (expiry_r & !clear_now);

  step_tick #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .restart(reload),
    .tick(tick)
  );

  // State registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= `RST_ENABLE;
      expiry_r <= 1'b0;
      period_r <= `RST_PERIOD;
      count_r <= `RST_PERIOD;
    end else begin
      enable_r <= enable_nxt;
      expiry_r <= expiry_nxt;
      period_r <= period_nxt;
      count_r <= count_nxt;
    end
  end

  //------------------------------------------------------------
  // Reply build
  //------------------------------------------------------------
  host_supervision_pkg::rsp_kind_t kind;
  logic [7:0] fn_out;
  logic [2:0] len_out;
  logic [31:0] pay_out;

  // Alive requests with data 0x0000 produce no reply; other data gets an exception
  assign kind = !take ? host_supervision_pkg::RSP_NONE :
                alive_ok ? host_supervision_pkg::RSP_NONE :
                value_ok ? host_supervision_pkg::RSP_DATA :
                host_supervision_pkg::RSP_EXCEPTION;

  // Payload per request kind; the flag reported is the state before this request
  always_comb begin
    fn_out = req_func;
    len_out = `LEN_ECHO;
    pay_out = {req_addr, req_data};
    case (kind)
      host_supervision_pkg::RSP_DATA: begin
        if (rd_expiry) begin
          len_out = `LEN_EXPIRY;
          pay_out = {8'h01, 7'h00, expiry_r, 16'h0000};
        end else if (rd_period) begin
          len_out = `LEN_PERIOD;
          pay_out = {8'h02, 8'h00, period_r, 8'h00};
        end
      end
      host_supervision_pkg::RSP_EXCEPTION: begin
        fn_out = req_func | `FN_EXCEPTION_BIT;
        len_out = `LEN_EXCEPTION;
        pay_out = {exc_code, 24'h000000};
      end
      default: begin
        len_out = `LEN_ECHO;
      end
    endcase
  end

  // Reply registers; valid is a one-cycle pulse one edge after the request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_func <= 8'h00;
      rsp_len <= 3'h0;
      rsp_payload <= 32'h00000000;
    end else begin
      rsp_valid <= (kind != host_supervision_pkg::RSP_NONE);
      if (kind != host_supervision_pkg::RSP_NONE) begin
        rsp_func <= fn_out;
        rsp_len <= len_out;
        rsp_payload <= pay_out;
      end
    end
  end

  // Visible state straight from flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_enabled <= `RST_ENABLE;
      expiry_flag <= 1'b0;
      period_value <= `RST_PERIOD;
    end else begin
      timer_enabled <= enable_nxt;
      expiry_flag <= expiry_nxt;
      period_value <= period_nxt;
    end
  end

endmodule : host_supervision_timer

// ### bench/host_supervision_timer_monitor.sv
// Checker of replies and timer state of the host supervision timer
`timescale 1ns/1ps
`include "host_supervision_defs.svh"

module host_supervision_timer_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request and reply
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_func,
  input wire logic [2:0] rsp_len,
  input wire logic [31:0] rsp_payload,
  // Timer state
  input wire logic timer_enabled,
  input wire logic expiry_flag,
  input wire logic [7:0] period_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Request decodes
  // ------------------------------------------------------------
  wire coil_w = req_valid && req_func == `FN_WRITE_COIL;
  wire en_w = coil_w && req_addr == `ITEM_ENABLE_COIL;
  wire on_off = req_data == `COIL_ON || req_data == `COIL_OFF;
  wire rd_one = req_valid && req_data == `QTY_ONE;
  wire per_w = req_valid && req_func == `FN_WRITE_REG && req_addr == `ITEM_PERIOD;
  wire alive = req_valid && req_addr == `ITEM_HOST_ALIVE && req_data == `ALIVE_DATA
    && (req_func == `FN_READ_HOLDING || req_func == `FN_READ_INPUT);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_alive_silent: assert property (alive |=> !rsp_valid)
    else $error("reply seen after host alive");
  a_enable_set: assert property (en_w && req_data == `COIL_ON |=> timer_enabled)
    else $error("timer not enabled");
  a_enable_clear: assert property (en_w && req_data == `COIL_OFF |=> !timer_enabled)
    else $error("timer not disabled");
  a_coil_echo: assert property (en_w && on_off |=> rsp_valid && rsp_func == `FN_WRITE_COIL
    && rsp_len == `LEN_ECHO && rsp_payload == {$past(req_addr), $past(req_data)})
    else $error("coil write echo wrong");
  a_bad_value: assert property (en_w && !on_off |=> rsp_valid && rsp_func == 8'h85
    && rsp_len == `LEN_EXCEPTION && $stable(timer_enabled))
    else $error("illegal coil value not refused");
  a_flag_clear: assert property (coil_w && req_addr == `ITEM_EXPIRY_FLAG
    && req_data == `COIL_ON && !timer_enabled |=> !expiry_flag)
    else $error("expiry flag not cleared");
  a_period_load: assert property (per_w && req_data <= `PERIOD_MAX |=>
    period_value == $past(req_data[7:0]) && rsp_payload == {$past(req_addr), $past(req_data)})
    else $error("period write wrong");
  a_period_read: assert property (rd_one && req_func == `FN_READ_HOLDING
    && req_addr == `ITEM_PERIOD |=> rsp_len == `LEN_PERIOD
    && rsp_payload == {16'h0200, $past(period_value), 8'h00})
    else $error("period read wrong");
  a_flag_read: assert property (rd_one && req_func == `FN_READ_COILS
    && req_addr == `ITEM_EXPIRY_FLAG |=> rsp_len == `LEN_EXPIRY
    && rsp_payload[31:16] == {8'h01, 7'h00, $past(expiry_flag)})
    else $error("expiry read wrong");
endmodule : host_supervision_timer_monitor

bind host_supervision_timer host_supervision_timer_monitor u_mon (.core_clk(core_clk),
  .rst_n(rst_n), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
  .req_data(req_data), .rsp_valid(rsp_valid), .rsp_func(rsp_func), .rsp_len(rsp_len),
  .rsp_payload(rsp_payload), .timer_enabled(timer_enabled), .expiry_flag(expiry_flag),
  .period_value(period_value));

// ### bench/modbus_master_model.sv
// Bus master model issuing decoded requests to the timer
`timescale 1ns/1ps

module modbus_master_model (
  // Clock
  input wire logic core_clk,
  // Decoded request
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_data
);
  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_data = 16'h0000;
  end
  // One request per call; fields inverted after release so stale data never matches
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_data = d;
    @(negedge core_clk);
    req_valid = 1'b0;
    req_func = ~f;
    req_addr = ~a;
    req_data = ~d;
  endtask : send
endmodule : modbus_master_model

// ### bench/host_supervision_timer_test.sv
// Self-checking testbench of the host supervision timer
`timescale 1ns/1ps
`include "host_supervision_defs.svh"

module host_supervision_timer_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, rsp_valid, timer_enabled, expiry_flag;
  logic [7:0] req_func, rsp_func, period_value;
  logic [15:0] req_addr, req_data;
  logic [2:0] rsp_len;
  logic [31:0] rsp_payload;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  // ------------------------------------------------------------
  // Clock, model and design
  // ------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  modbus_master_model mst (.core_clk(core_clk), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_data(req_data));
  // Short step keeps the countdown tests brief
  host_supervision_timer #(.STEP_CYCLES(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_func(rsp_func), .rsp_len(rsp_len), .rsp_payload(rsp_payload),
    .timer_enabled(timer_enabled), .expiry_flag(expiry_flag), .period_value(period_value));
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request, then the reply seen in the cycle it stands
  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                     input logic [7:0] ef, input logic [2:0] el, input logic [31:0] ep);
    mst.send(f, a, d);
    chk({rsp_valid, rsp_func, rsp_len}, {1'b1, ef, el});
    chk(rsp_payload, ep);
  endtask : req
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_coil();
    req(8'h05, 16'h0104, 16'hFF00, 8'h05, 3'h4, 32'h0104FF00);
    chk(timer_enabled, 1'b1);
    req(8'h05, 16'h0104, 16'h1234, 8'h85, 3'h1, 32'h03000000);
    chk(timer_enabled, 1'b1);
    req(8'h05, 16'h0104, 16'h0000, 8'h05, 3'h4, 32'h01040000);
    chk(timer_enabled, 1'b0);
    $display("coil test done");
  endtask : t_coil
  task automatic t_period();
    req(8'h06, 16'h01E8, 16'h0005, 8'h06, 3'h4, 32'h01E80005);
    req(8'h03, 16'h01E8, 16'h0001, 8'h03, 3'h3, 32'h02000500);
    req(8'h06, 16'h01E8, 16'h0100, 8'h86, 3'h1, 32'h03000000);
    chk(period_value, 8'h05);
    $display("period test done");
  endtask : t_period
  // Each exception code, including the unknown function and the wrong item
  task automatic t_refuse();
    req(8'h10, 16'h0104, 16'hFF00, 8'h90, 3'h1, 32'h01000000);
    chk(timer_enabled, 1'b0);
    req(8'h05, 16'h0105, 16'hFF00, 8'h85, 3'h1, 32'h02000000);
    req(8'h01, 16'h010D, 16'h0002, 8'h81, 3'h1, 32'h03000000);
    req(8'h03, 16'h01E8, 16'h0002, 8'h83, 3'h1, 32'h03000000);
    req(8'h04, 16'h3038, 16'h0001, 8'h84, 3'h1, 32'h03000000);
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_expiry();
    req(8'h05, 16'h0104, 16'hFF00, 8'h05, 3'h4, 32'h0104FF00);
    // Alive every 16 cycles, well inside the 40-cycle period
    for (int i = 0; i < 6; i++) begin
      repeat (14) @(negedge core_clk);
      mst.send(i[0] ? 8'h03 : 8'h04, 16'h3038, 16'h0000);
      chk(rsp_valid, 1'b0);
      chk(expiry_flag, 1'b0);
    end
    repeat (60) @(negedge core_clk);
    chk(expiry_flag, 1'b1);
    req(8'h01, 16'h010D, 16'h0001, 8'h01, 3'h2, 32'h01010000);
    req(8'h05, 16'h0104, 16'h0000, 8'h05, 3'h4, 32'h01040000);
    chk(expiry_flag, 1'b1);
    // A clear with the off value is illegal and must leave the flag set
    req(8'h05, 16'h010D, 16'h0000, 8'h85, 3'h1, 32'h03000000);
    chk(expiry_flag, 1'b1);
    req(8'h05, 16'h010D, 16'hFF00, 8'h05, 3'h4, 32'h010DFF00);
    chk(expiry_flag, 1'b0);
    req(8'h01, 16'h010D, 16'h0001, 8'h01, 3'h2, 32'h01000000);
    $display("expiry test done");
  endtask : t_expiry
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_coil();
    t_period();
    t_refuse();
    t_expiry();
    summarize();
  end
endmodule : host_supervision_timer_test
